// ---- dv/gas_cfg_regs_assertions.sv ----
`timescale 1ns/100ps
module gas_cfg_regs_checker (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   nrst,
  // Watched ports
  input wire logic                   scl_i,
  input wire logic                   calc_start,
  input wire gas_cfg_pkg::filt_cfg_t filt_cfg,
  input wire gas_cfg_pkg::cal_req_t  cal_req,
  input wire logic                   soft_rst,
  input wire logic [6:0]             bus_addr_active
);
  import gas_cfg_pkg::*;
  // ****************
  // Port relations
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  cal_pulse_a: assert property (
    cal_req.start |=> !cal_req.start) else $error("calibration start longer than one cycle");
  tgt_hold_a: assert property (
    $changed(cal_req.target) |-> cal_req.start || soft_rst) else $error("target moved alone");
  rst_pulse_a: assert property (
    soft_rst |=> !soft_rst) else $error("soft reset longer than one cycle");
  addr_wait_a: assert property (
    $changed(bus_addr_active) |-> soft_rst) else $error("address changed without reset");
  press_next_a: assert property (
    $changed(filt_cfg.press_used) || $changed(filt_cfg.press_comp_on)
    |-> $past(calc_start) || soft_rst) else $error("pressure used outside calculation");
  clamp_range_a: assert property (
    filt_cfg.press_comp_on |-> $signed(filt_cfg.press_used) >= 16'sd3000
    && $signed(filt_cfg.press_used) <= 16'sd13000) else $error("pressure out of range");
  clamp_flag_a: assert property (
    filt_cfg.press_clamped |-> filt_cfg.press_used == PRESS_MIN
    || filt_cfg.press_used == PRESS_MAX) else $error("clamped value not a limit");
  dyn_sync_a: assert property (
    $changed(filt_cfg.dyn_iir_on) |-> scl_i) else $error("dynamic filter moved off a write");
  stat_sync_a: assert property (
    $changed(filt_cfg.static_iir_on) |-> scl_i) else $error("static filter moved off a write");
endmodule

bind gas_cfg_regs gas_cfg_regs_checker u_chk (
  .clk, .nrst, .scl_i, .calc_start, .filt_cfg, .cal_req, .soft_rst, .bus_addr_active
);

// ---- dv/gas_cfg_regs_test.sv ----
`timescale 1ns/100ps
module gas_cfg_regs_test;
  import gas_cfg_pkg::*;
  // ****************
  // Bench
  // ****************
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        calc_start = 1'b0;
  logic        cal_done = 1'b0;
  logic        cal_ok = 1'b0;
  logic        scl;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe;
  logic        soft_rst;
  logic [6:0]  bus_addr_active;
  filt_cfg_t   filt_cfg;
  cal_req_t    cal_req;
  cal_req_t    req_q;
  wire         sda = ~(sda_low | sda_oe);
  int          n_req = 0;
  int          n_srst = 0;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [15:0] d;
  logic [15:0] pv [5] = '{16'h26F2, 16'h0BB7, 16'h32C9, 16'h8000, 16'h0BB8};
  logic [15:0] pu [5] = '{16'h26F2, PRESS_MIN, PRESS_MAX, PRESS_MIN, PRESS_MIN};
  logic [4:0]  pc = 5'b01110;

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (cal_req.start === 1'b1) begin
      n_req <= n_req + 1;
      req_q <= cal_req;
    end
    if (soft_rst === 1'b1) n_srst <= n_srst + 1;
  end

  gas_cfg_regs u_dut (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .calc_start(calc_start), .cal_done(cal_done), .cal_ok(cal_ok),
    .filt_cfg(filt_cfg), .cal_req(cal_req), .soft_rst(soft_rst),
    .bus_addr_active(bus_addr_active));
  i2c_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  task chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task calc;
    calc_start = 1'b1;
    tick(1);
    calc_start = 1'b0;
    tick(1);
  endtask
  task done(input logic ok);
    cal_ok = ok;
    cal_done = 1'b1;
    tick(1);
    cal_done = 1'b0;
    tick(1);
  endtask
  task rdc(input logic [6:0] a, input logic [7:0] p, input int n, input logic [15:0] e,
           input string nm);
    u_host.rd(a, p, d, n);
    chk({nm, " ack"}, 20'h1, u_host.ack_all);
    chk(nm, e, d);
  endtask

  task t_reset;
    chk("addr", DEF_BUS_ADDR, bus_addr_active);
    chk("filt", 20'h00000, filt_cfg);
    chk("sda_o", 20'h00000, sda_o);
    rdc(DEF_BUS_ADDR, OFS_FEAT, 1, FEAT_RST, "feat");
    rdc(DEF_BUS_ADDR, OFS_CAL_STAT, 1, STAT_RST, "stat");
  endtask
  task t_filt;
    u_host.wr(DEF_BUS_ADDR, OFS_FEAT, 16'h00F3, 1);
    chk("iir on", 20'h3, {filt_cfg.static_iir_on, filt_cfg.dyn_iir_on});
    u_host.wr(DEF_BUS_ADDR, OFS_FEAT, 16'h00FC, 1);
    chk("iir off", 20'h0, {filt_cfg.static_iir_on, filt_cfg.dyn_iir_on});
    rdc(DEF_BUS_ADDR, OFS_FEAT, 1, 16'h00FC, "feat");
  endtask
  task t_cal(input logic [15:0] cmd, input logic [7:0] st);
    int n;
    n = n_req;
    u_host.wr(DEF_BUS_ADDR, OFS_CAL_STAT, 16'h0000, 1);
    u_host.wr(DEF_BUS_ADDR, OFS_CAL_TGT_HI, 16'h01F4, 2);
    u_host.wr(DEF_BUS_ADDR, OFS_CAL_CMD_HI, cmd, 2);
    chk("starts", 20'h1, 20'(n_req - n));
    chk("mode", {19'h0, st == STAT_TGT_OK}, req_q.target_mode);
    if (st == STAT_TGT_OK) chk("target", 20'h01F4, req_q.target);
    done(1'b0);
    rdc(DEF_BUS_ADDR, OFS_CAL_STAT, 1, 16'h0000, "fail stat");
    done(1'b1);
    rdc(DEF_BUS_ADDR, OFS_CAL_STAT, 1, {8'h00, st}, "stat");
    tick(300);
    rdc(DEF_BUS_ADDR, OFS_CAL_STAT, 1, {8'h00, st}, "held");
  endtask
  task t_press;
    logic [15:0] last_u;
    last_u = PRESS_MIN;
    u_host.wr(DEF_BUS_ADDR, OFS_FEAT, 16'h00E0, 1);
    calc;
    chk("comp unset", 20'h0, filt_cfg.press_comp_on);
    for (int i = 0; i < 5; i++) begin
      u_host.wr(DEF_BUS_ADDR, OFS_PRESS_HI, pv[i], 2);
      chk("press hold", {4'h0, last_u}, filt_cfg.press_used);
      calc;
      chk("press", {3'b111, pc[i], pu[i]}, filt_cfg);
      rdc(DEF_BUS_ADDR, OFS_PRESS_HI, 2, pv[i], "press rd");
      last_u = pu[i];
    end
    u_host.wr(DEF_BUS_ADDR, OFS_FEAT, 16'h00F0, 1);
    calc;
    chk("comp off", 20'h0, filt_cfg.press_comp_on);
  endtask
  task t_addr;
    int n;
    n = n_srst;
    u_host.wr(DEF_BUS_ADDR, OFS_BUS_ADDR, 16'h000A, 1);
    chk("addr kept", DEF_BUS_ADDR, bus_addr_active);
    rdc(DEF_BUS_ADDR, OFS_BUS_ADDR, 1, 16'h000A, "addr reg");
    u_host.wr(DEF_BUS_ADDR, OFS_SW_RST, 16'h00FF, 1);
    chk("resets", 20'h1, 20'(n_srst - n));
    chk("addr new", 20'h0A, bus_addr_active);
    rdc(7'h0A, OFS_FEAT, 1, FEAT_RST, "feat new");
    u_host.rd(DEF_BUS_ADDR, OFS_FEAT, d, 1);
    chk("old ack", 20'h0, u_host.ack_all);
  endtask

  task conclude;
    $display("Compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(2);
    nrst = 1'b1;
    tick(6);
    t_reset;
    t_filt;
    t_cal(CMD_BG_CAL, STAT_BG_OK);
    t_cal(CMD_TGT_CAL, STAT_TGT_OK);
    t_press;
    t_addr;
    conclude;
  end
  initial begin
    #(60000 * 25);
    fail_count++;
    conclude;
  end
endmodule

// ---- dv/i2c_host.sv ----
`timescale 1ns/100ps
module i2c_host (
  // Clock and bus
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // ****************
  // Bus master
  // ****************
  logic ack_all;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack_all = 1'b1;
  end
  task hp;
    repeat (12) @(posedge clk);
    #1;
  endtask
  task start;
    sda_low = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_low = 1'b1;
    hp;
    scl = 1'b0;
  endtask
  task stop;
    sda_low = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_low = 1'b0;
    hp;
  endtask
  task bit_cyc(output logic b);
    hp;
    scl = 1'b1;
    hp;
    b = sda;
    scl = 1'b0;
  endtask
  task put(input logic [7:0] v);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~v[i];
      bit_cyc(b);
    end
    sda_low = 1'b0;
    bit_cyc(b);
    ack_all = ack_all & ~b;
  endtask
  task get(output logic [7:0] v, input logic last);
    logic b;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b);
      v[i] = b;
    end
    sda_low = ~last;
    bit_cyc(b);
    sda_low = 1'b0;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v, input int n);
    ack_all = 1'b1;
    start;
    put({a, 1'b0});
    put(p);
    if (n == 2) put(v[15:8]);
    put(v[7:0]);
    stop;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] v, input int n);
    logic [7:0] x;
    ack_all = 1'b1;
    v = 16'h0000;
    start;
    put({a, 1'b0});
    put(p);
    start;
    put({a, 1'b1});
    for (int k = 0; k < n; k++) begin
      get(x, k == n - 1);
      v = {v[7:0], x};
    end
    stop;
  endtask
endmodule

// ---- pkg/gas_cfg_pkg.sv ----
package gas_cfg_pkg;

  // ****************************************
  // Bus address
  // ****************************************
  localparam logic [6:0]  DEF_BUS_ADDR   = 7'h68;
  localparam logic [7:0]  BUS_ADDR_RST   = 8'h68;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0]  OFS_CAL_STAT   = 8'h81;
  localparam logic [7:0]  OFS_CAL_CMD_HI = 8'h82;
  localparam logic [7:0]  OFS_CAL_CMD_LO = 8'h83;
  localparam logic [7:0]  OFS_CAL_TGT_HI = 8'h84;
  localparam logic [7:0]  OFS_CAL_TGT_LO = 8'h85;
  localparam logic [7:0]  OFS_SW_RST     = 8'hA3;
  localparam logic [7:0]  OFS_FEAT       = 8'hA5;
  localparam logic [7:0]  OFS_BUS_ADDR   = 8'hA7;
  localparam logic [7:0]  OFS_PRESS_HI   = 8'hDC;
  localparam logic [7:0]  OFS_PRESS_LO   = 8'hDD;

  // ****************************************
  // Feature control fields and reset values
  // ****************************************
  localparam int          FEAT_STATIC_OFF = 2;
  localparam int          FEAT_DYN_OFF    = 3;
  localparam int          FEAT_PCOMP_OFF  = 4;
  localparam logic [7:0]  FEAT_RST        = 8'hFF;
  localparam logic [7:0]  STAT_RST        = 8'h00;
  localparam logic [15:0] WORD_RST        = 16'h0000;

  // ****************************************
  // Commands and results
  // ****************************************
  localparam logic [7:0]  SW_RST_KEY     = 8'hFF;
  localparam logic [15:0] CMD_BG_CAL     = 16'h7C06;
  localparam logic [15:0] CMD_TGT_CAL    = 16'h7C05;
  localparam logic [7:0]  STAT_BG_OK     = 8'h20;
  localparam logic [7:0]  STAT_TGT_OK    = 8'h10;

  // ****************************************
  // Pressure limits, 0.1 hPa units
  // ****************************************
  localparam logic [15:0] PRESS_MIN      = 16'h0BB8;
  localparam logic [15:0] PRESS_MAX      = 16'h32C8;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        static_iir_on;
    logic        dyn_iir_on;
    logic        press_comp_on;
    logic        press_clamped;
    logic [15:0] press_used;
  } filt_cfg_t;

  typedef struct packed {
    logic        start;
    logic        target_mode;
    logic [15:0] target;
  } cal_req_t;

endpackage

// ---- src/gas_cfg_regs.sv ----
`timescale 1ns/100ps
//
// Contract
// - Both filter bits clear: static and dynamic filters on
// - Both filter bits set: bypass filters
// - Word 0x7C06 starts background calibration
// - Background success reports 0x20
// - Target then 0x7C05 starts target calibration
// - Target success reports 0x10
// - New address waits for a reset
// - 0xFF to reset register resets device
// - Bit 4 clear enables pressure compensation
// - Bit 4 set disables pressure compensation
// - Compensate only when enabled and written
// - Out of range pressure clamps to limits
// - New pressure used at next calculation
// - Pressure signed, MSB at lower offset
//
module gas_cfg_regs (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // I2C pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  // Measurement core
  input  wire logic                  calc_start,
  input  wire logic                  cal_done,
  input  wire logic                  cal_ok,
  output gas_cfg_pkg::filt_cfg_t     filt_cfg,
  output gas_cfg_pkg::cal_req_t      cal_req,
  // Device control
  output logic                       soft_rst,
  output logic [6:0]                 bus_addr_active
);
  import gas_cfg_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] pin_raw;
  logic [1:0] pin_s;
  logic       scl_s;
  logic       sda_s;

  assign pin_raw = {scl_i, sda_i};
  assign scl_s   = pin_s[1];
  assign sda_s   = pin_s[0];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      pin_sync u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (pin_raw[gi]),
        .dout (pin_s[gi])
      );
    end
  endgenerate

  // ****************************************
  // Bus engine
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
  } bus_st_t;

  bus_st_t    st_ff,  nxt_st;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff,  nxt_sh;
  logic [7:0] ptr_ff, nxt_ptr;
  logic       rnw_ff, nxt_rnw;
  logic       first_ff, nxt_first;
  logic       scl_q_ff, sda_q_ff;
  logic       nxt_sda_oe;
  logic       start_c, stop_c, rise_c, fall_c;
  logic [7:0] byte_c;
  logic [7:0] rd_data;
  logic       wr_stb;
  logic [7:0] wr_ofs;
  logic [7:0] wr_dat;

  assign start_c = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_c  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign rise_c  = scl_s & ~scl_q_ff;
  assign fall_c  = ~scl_s & scl_q_ff;
  assign byte_c  = {sh_ff[6:0], sda_s};

  always_comb begin
    nxt_st     = st_ff;
    nxt_bit    = bit_ff;
    nxt_sh     = sh_ff;
    nxt_ptr    = ptr_ff;
    nxt_rnw    = rnw_ff;
    nxt_first  = first_ff;
    nxt_sda_oe = sda_oe;
    wr_stb     = 1'b0;
    wr_ofs     = ptr_ff;
    wr_dat     = byte_c;
    if (start_c) begin
      nxt_st     = ST_ADDR;
      nxt_bit    = 3'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_c) begin
      nxt_st     = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (rise_c) begin
            nxt_sh  = byte_c;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              nxt_rnw = byte_c[0];
              nxt_st  = (byte_c[7:1] == bus_addr_active) ? ST_AACK : ST_IDLE;
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (fall_c && !sda_oe) begin
            nxt_sda_oe = 1'b1;
          end else if (fall_c) begin
            nxt_bit = 3'h0;
            if (st_ff == ST_AACK && rnw_ff) begin
              nxt_st     = ST_RD;
              nxt_sh     = rd_data;
              nxt_sda_oe = ~rd_data[7];
            end else begin
              nxt_st     = ST_WR;
              nxt_sda_oe = 1'b0;
              if (st_ff == ST_AACK) begin
                nxt_first = 1'b1;
              end
            end
          end
        end
        ST_WR: begin
          if (rise_c) begin
            nxt_sh  = byte_c;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              nxt_st = ST_WACK;
              if (first_ff) begin
                nxt_ptr   = byte_c;
                nxt_first = 1'b0;
              end else begin
                wr_stb  = 1'b1;
                nxt_ptr = ptr_ff + 8'h01;
              end
            end
          end
        end
        ST_RD: begin
          if (fall_c) begin
            if (bit_ff == 3'h7) begin
              nxt_st     = ST_RACK;
              nxt_sda_oe = 1'b0;
              nxt_ptr    = ptr_ff + 8'h01;
            end else begin
              nxt_bit    = bit_ff + 3'h1;
              nxt_sh     = {sh_ff[6:0], 1'b0};
              nxt_sda_oe = ~sh_ff[6];
            end
          end
        end
        ST_RACK: begin
          if (rise_c) begin
            nxt_sh = {7'h00, sda_s};
          end else if (fall_c) begin
            if (sh_ff[0]) begin
              nxt_st = ST_IDLE;
            end else begin
              nxt_st     = ST_RD;
              nxt_bit    = 3'h0;
              nxt_sh     = rd_data;
              nxt_sda_oe = ~rd_data[7];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff    <= ST_IDLE;
      bit_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      ptr_ff   <= 8'h00;
      rnw_ff   <= 1'b0;
      first_ff <= 1'b0;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      sda_oe   <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      bit_ff   <= nxt_bit;
      sh_ff    <= nxt_sh;
      ptr_ff   <= nxt_ptr;
      rnw_ff   <= nxt_rnw;
      first_ff <= nxt_first;
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      sda_oe   <= nxt_sda_oe;
      sda_o    <= 1'b0;
    end
  end

  // ****************************************
  // Register bank
  // ****************************************
  logic [7:0]  stat_ff,  nxt_stat;
  logic [15:0] cmd_ff,   nxt_cmd;
  logic [15:0] tgt_ff,   nxt_tgt;
  logic [7:0]  feat_ff,  nxt_feat;
  logic [7:0]  addr_ff,  nxt_addr;
  logic [15:0] press_ff, nxt_press;
  logic        pvalid_ff, nxt_pvalid;
  logic        rpend_ff, nxt_rpend;
  filt_cfg_t   nxt_filt;
  cal_req_t    nxt_cal;
  logic        nxt_soft_rst;
  logic [6:0]  nxt_act;
  logic [15:0] clamp_c;
  logic        clamped_c;

  always_comb begin
    unique case (ptr_ff)
      OFS_CAL_STAT:   rd_data = stat_ff;
      OFS_CAL_CMD_HI: rd_data = cmd_ff[15:8];
      OFS_CAL_CMD_LO: rd_data = cmd_ff[7:0];
      OFS_CAL_TGT_HI: rd_data = tgt_ff[15:8];
      OFS_CAL_TGT_LO: rd_data = tgt_ff[7:0];
      OFS_FEAT:       rd_data = feat_ff;
      OFS_BUS_ADDR:   rd_data = addr_ff;
      OFS_PRESS_HI:   rd_data = press_ff[15:8];
      OFS_PRESS_LO:   rd_data = press_ff[7:0];
      default:        rd_data = 8'h00;
    endcase
  end

  always_comb begin
    if ($signed(press_ff) < $signed(PRESS_MIN)) begin
      clamp_c   = PRESS_MIN;
      clamped_c = 1'b1;
    end else if ($signed(press_ff) > $signed(PRESS_MAX)) begin
      clamp_c   = PRESS_MAX;
      clamped_c = 1'b1;
    end else begin
      clamp_c   = press_ff;
      clamped_c = 1'b0;
    end
  end

  always_comb begin
    nxt_stat     = stat_ff;
    nxt_cmd      = cmd_ff;
    nxt_tgt      = tgt_ff;
    nxt_feat     = feat_ff;
    nxt_addr     = addr_ff;
    nxt_press    = press_ff;
    nxt_pvalid   = pvalid_ff;
    nxt_rpend    = rpend_ff;
    nxt_filt     = filt_cfg;
    nxt_cal      = cal_req;
    nxt_cal.start = 1'b0;
    nxt_soft_rst = 1'b0;
    nxt_act      = bus_addr_active;
    if (wr_stb) begin
      unique case (wr_ofs)
        OFS_CAL_STAT:   nxt_stat = wr_dat;
        OFS_CAL_CMD_HI: nxt_cmd[15:8] = wr_dat;
        OFS_CAL_CMD_LO: begin
          nxt_cmd[7:0] = wr_dat;
          if ({cmd_ff[15:8], wr_dat} == CMD_BG_CAL) begin
            nxt_cal.start       = 1'b1;
            nxt_cal.target_mode = 1'b0;
          end
          if ({cmd_ff[15:8], wr_dat} == CMD_TGT_CAL) begin
            nxt_cal.start       = 1'b1;
            nxt_cal.target_mode = 1'b1;
            nxt_cal.target      = tgt_ff;
          end
        end
        OFS_CAL_TGT_HI: nxt_tgt[15:8] = wr_dat;
        OFS_CAL_TGT_LO: nxt_tgt[7:0] = wr_dat;
        OFS_SW_RST:     nxt_rpend = rpend_ff | (wr_dat == SW_RST_KEY);
        OFS_FEAT:       nxt_feat = wr_dat;
        OFS_BUS_ADDR:   nxt_addr = wr_dat;
        OFS_PRESS_HI:   nxt_press[15:8] = wr_dat;
        OFS_PRESS_LO: begin
          nxt_press[7:0] = wr_dat;
          nxt_pvalid     = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (cal_done && cal_ok) begin
      nxt_stat = cal_req.target_mode ? STAT_TGT_OK : STAT_BG_OK;
    end
    nxt_filt.dyn_iir_on    = ~feat_ff[FEAT_DYN_OFF];
    nxt_filt.static_iir_on = ~feat_ff[FEAT_STATIC_OFF];
    if (calc_start) begin
      nxt_filt.press_comp_on = ~feat_ff[FEAT_PCOMP_OFF] & pvalid_ff;
      nxt_filt.press_used    = clamp_c;
      nxt_filt.press_clamped = clamped_c & pvalid_ff;
    end
    // Soft reset at end of transfer
    if (stop_c && rpend_ff) begin
      nxt_stat     = STAT_RST;
      nxt_cmd      = WORD_RST;
      nxt_tgt      = WORD_RST;
      nxt_feat     = FEAT_RST;
      nxt_press    = WORD_RST;
      nxt_pvalid   = 1'b0;
      nxt_rpend    = 1'b0;
      nxt_filt     = '0;
      nxt_cal      = '0;
      nxt_soft_rst = 1'b1;
      nxt_act      = addr_ff[6:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_ff         <= STAT_RST;
      cmd_ff          <= WORD_RST;
      tgt_ff          <= WORD_RST;
      feat_ff         <= FEAT_RST;
      addr_ff         <= BUS_ADDR_RST;
      press_ff        <= WORD_RST;
      pvalid_ff       <= 1'b0;
      rpend_ff        <= 1'b0;
      filt_cfg        <= '0;
      cal_req         <= '0;
      soft_rst        <= 1'b0;
      bus_addr_active <= DEF_BUS_ADDR;
    end else begin
      // Status only moves on write, result or soft reset
      stat_ff         <= nxt_stat;
      cmd_ff          <= nxt_cmd;
      tgt_ff          <= nxt_tgt;
      feat_ff         <= nxt_feat;
      addr_ff         <= nxt_addr;
      press_ff        <= nxt_press;
      pvalid_ff       <= nxt_pvalid;
      rpend_ff        <= nxt_rpend;
      filt_cfg        <= nxt_filt;
      cal_req         <= nxt_cal;
      soft_rst        <= nxt_soft_rst;
      bus_addr_active <= nxt_act;
    end
  end

endmodule

// ---- src/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Pin in, filtered level out
  input  wire logic din,
  output logic      dout
);

  // ****************************************
  // Three stage sampler
  // ****************************************
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic nxt_dout;

  always_comb begin
    nxt_dout = (s2_ff == s3_ff) ? s3_ff : dout;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      dout  <= 1'b1;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      dout  <= nxt_dout;
    end
  end

endmodule
